// >>> hw/wheel_speed_pkg.sv
//------------------------------------------------------------------------------
// Purpose: Constants shared by the wheel-speed channel control logic.
// Assumes: Eight-bit register port, four sensor channels, two open-drain outputs.
// Notes:   Offsets are the register addresses seen on the register port.
//------------------------------------------------------------------------------
package wheel_speed_pkg;

  // ---------------------------------------------------------------------------
  // Structure
  // ---------------------------------------------------------------------------
  localparam int CHANNELS = 4;
  localparam int OD_CHANNELS = 2;
  localparam int THRESHOLDS = 4;
  localparam int DIAG_BITS = 9;
  localparam int SYNC_W = 49;

  // ---------------------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OFF_COUNT = 8'h04;
  localparam logic [7:0] OFF_OD_COUNT_FLAGS = 8'h05;
  localparam logic [7:0] OFF_STB1 = 8'h08;
  localparam logic [7:0] OFF_STB2 = 8'h0a;
  localparam logic [7:0] OFF_STB3 = 8'h0c;
  localparam logic [7:0] OFF_STB4 = 8'h0e;
  localparam logic [7:0] OFF_SENSE_FAULTS = 8'h0f;
  localparam logic [7:0] OFF_SUPPLY_EN = 8'h1b;
  localparam logic [7:0] OFF_RETURN_EN = 8'h1c;
  localparam logic [7:0] OFF_TYPE_LIMIT = 8'h1d;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int STB_BIT = 0;
  localparam int RET_OC_LSB = 0;
  localparam int SENSE_FAULT_LSB = 4;
  localparam int SUP_EN_LSB = 0;
  localparam int RET_EN_LSB = 0;
  localparam int OD_EN_LSB = 4;
  localparam int TYPE_BIT = 0;
  localparam int SEL0_BIT = 1;
  localparam int SEL1_BIT = 2;
  localparam int SUP_OC_LSB = 4;
  localparam int OD_LIM_LSB = 0;
  localparam int OD_GND_LSB = 2;
  localparam int CNT_OVF_BIT = 4;
  localparam int CNT_CONF_BIT = 5;

  // ---------------------------------------------------------------------------
  // Values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] COUNT_MAX = 8'hff;
  localparam logic [3:0] DIAG_LAST = 4'h8;
  localparam logic TYPE_INTELLIGENT = 1'b0;

endpackage

// >>> hw/wheel_speed_channel_control.sv
//------------------------------------------------------------------------------
// Purpose: Switch control, current classification, fault flags and edge
//          counter for four current-encoded wheel-speed sensor channels.
// Assumes: Comparator and fault inputs are asynchronous analog results.
// Notes:   Fault flags clear on a read only once their cause has gone.
//------------------------------------------------------------------------------
`timescale 1ns/1ps

module wheel_speed_channel_control (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Register port.
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // Comparator results, bit ch*4+k is above threshold k+1 on channel ch.
  input wire logic [15:0] threshold_above_i,
  // Per-channel fault detectors.
  input wire logic [3:0] supply_overcurrent_i,
  input wire logic [3:0] supply_battery_short_status_i,
  input wire logic [3:0] return_overcurrent_i,
  input wire logic [3:0] sense_battery_short_i,
  input wire logic [3:0] sense_ground_short_i,
  input wire logic [3:0] return_ground_short_i,
  input wire logic [1:0] open_drain_overcurrent_i,
  input wire logic [1:0] open_drain_ground_short_i,
  // Supervisor events and counter pins.
  input wire logic supply_undervoltage_i,
  input wire logic battery_overvoltage_i,
  input wire logic reset_out_pin_i,
  input wire logic count_clear_pin_i,
  input wire logic count_enable_pin_i,
  // Switch drives.
  output logic [3:0] sensor_supply_switch_o,
  output logic [3:0] sensor_return_switch_o,
  output logic [1:0] open_drain_speed_out_o,
  output logic [1:0] open_drain_speed_out_oe_o,
  // Open-drain reset output.
  output logic reset_out_pin_o,
  output logic reset_out_pin_oe_o,
  // Decoded sensor information.
  output logic [3:0] digital_speed_out_o,
  output logic [3:0] sensor_undercurrent_o,
  output logic [3:0] sensor_overcurrent_o,
  output logic [35:0] diag_words_o,
  output logic [7:0] pulse_count_o
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [wheel_speed_pkg::SYNC_W-1:0] sync1;
    logic [wheel_speed_pkg::SYNC_W-1:0] sync2;
    logic [3:0] sup_en;
    logic [3:0] ret_en;
    logic [1:0] od_en;
    logic sensor_type;
    logic [1:0] cnt_sel;
    logic [3:0] stb_flag;
    logic [3:0] sup_oc_flag;
    logic [3:0] ret_oc_flag;
    logic [3:0] sense_fault_flag;
    logic [1:0] od_lim_flag;
    logic [1:0] od_gnd_flag;
    logic cnt_ovf_flag;
    logic cnt_conf_flag;
    logic [3:0] speed;
    logic [3:0] under;
    logic [3:0] over;
    logic [7:0] count;
    logic [3:0] diag_seen;
    logic [3:0][3:0] diag_cnt;
    logic [3:0][8:0] diag_shift;
    logic [3:0][8:0] diag_word;
    logic [7:0] rdata;
  } state_t;

  state_t st;
  state_t next_st;

  // ---------------------------------------------------------------------------
  // Input synchronisation
  // ---------------------------------------------------------------------------
  // Raw asynchronous inputs gathered into one bus for the two-stage chain.
  logic [wheel_speed_pkg::SYNC_W-1:0] async_in;
  assign async_in = {threshold_above_i, supply_overcurrent_i, supply_battery_short_status_i,
                     return_overcurrent_i, sense_battery_short_i, sense_ground_short_i,
                     return_ground_short_i, open_drain_overcurrent_i,
                     open_drain_ground_short_i, supply_undervoltage_i, battery_overvoltage_i,
                     reset_out_pin_i, count_clear_pin_i, count_enable_pin_i};

  // Synchronised copies, taken only from the second stage.
  logic [15:0] thr;
  logic [3:0] sup_oc;
  logic [3:0] sup_vbat;
  logic [3:0] ret_oc;
  logic [3:0] sns_stb;
  logic [3:0] sns_stg;
  logic [3:0] ret_stg;
  logic [1:0] od_oc;
  logic [1:0] od_stg;
  logic uv;
  logic ov;
  logic rst_pin;
  logic count_clear_pin;
  logic cnt_en;
  assign {thr, sup_oc, sup_vbat, ret_oc, sns_stb, sns_stg, ret_stg, od_oc, od_stg,
          uv, ov, rst_pin, count_clear_pin, cnt_en} = st.sync2;

  // ---------------------------------------------------------------------------
  // Switch drives
  // ---------------------------------------------------------------------------
  // Supervisor shutdown; the pin counts as pulled low only when not driven here.
  logic shutdown;
  assign shutdown = uv | ov | (~rst_pin & ~uv);

  // Supply drops on its own flags only, return on its own, open-drain likewise.
  assign sensor_supply_switch_o = st.sup_en & ~st.sup_oc_flag & ~st.stb_flag
                                  & {4{~shutdown}};
  assign sensor_return_switch_o = st.ret_en & ~st.ret_oc_flag & {4{~shutdown}};
  // A high speed level pulls the open-drain pin low.
  assign open_drain_speed_out_oe_o = st.od_en & st.speed[1:0] & ~st.od_lim_flag
                                     & {2{~shutdown}};
  assign open_drain_speed_out_o = 2'h0;

  // Reset output is pulled low during supply undervoltage.
  assign reset_out_pin_o = 1'b0;
  assign reset_out_pin_oe_o = uv;

  // Registered data outputs.
  assign reg_rdata_o = st.rdata;
  assign digital_speed_out_o = st.speed;
  assign sensor_undercurrent_o = st.under;
  assign sensor_overcurrent_o = st.over;
  assign diag_words_o = st.diag_word;
  assign pulse_count_o = st.count;

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  // Fault conditions, read strobes and the selected counter input.
  logic [3:0] stb_cond;
  logic [3:0] ret_cond;
  logic [3:0] sense_cond;
  logic [1:0] od_gnd_cond;
  logic rd_stb_hit [4];
  logic rd_sense;
  logic rd_limit;
  logic rd_od;
  logic [1:0] sel_idx;
  logic sel_edge;
  assign stb_cond = sup_vbat & ~sensor_supply_switch_o;
  assign ret_cond = ret_oc | sns_stb;
  assign sense_cond = sns_stg | ret_stg;
  assign od_gnd_cond = od_stg & ~open_drain_speed_out_oe_o;
  assign rd_stb_hit[0] = reg_rd_i && reg_addr_i == wheel_speed_pkg::OFF_STB1;
  assign rd_stb_hit[1] = reg_rd_i && reg_addr_i == wheel_speed_pkg::OFF_STB2;
  assign rd_stb_hit[2] = reg_rd_i && reg_addr_i == wheel_speed_pkg::OFF_STB3;
  assign rd_stb_hit[3] = reg_rd_i && reg_addr_i == wheel_speed_pkg::OFF_STB4;
  assign rd_sense = reg_rd_i && reg_addr_i == wheel_speed_pkg::OFF_SENSE_FAULTS;
  assign rd_limit = reg_rd_i && reg_addr_i == wheel_speed_pkg::OFF_TYPE_LIMIT;
  assign rd_od = reg_rd_i && reg_addr_i == wheel_speed_pkg::OFF_OD_COUNT_FLAGS;
  assign sel_idx = {st.cnt_sel[0], st.cnt_sel[1]};

  // Fills the next copy of the whole state.
  always_comb begin
    logic t1;
    logic t2;
    logic t3;
    logic t4;
    logic [7:0] rd;
    next_st = st;
    t1 = 1'b0;
    t2 = 1'b0;
    t3 = 1'b0;
    t4 = 1'b0;
    rd = 8'h00;
    next_st.sync1 = async_in;
    next_st.sync2 = st.sync1;

    // Per-channel classification, flags and diagnostic decoding.
    for (int ch = 0; ch < wheel_speed_pkg::CHANNELS; ch++) begin
      t1 = thr[ch*wheel_speed_pkg::THRESHOLDS];
      t2 = thr[ch*wheel_speed_pkg::THRESHOLDS+1];
      t3 = thr[ch*wheel_speed_pkg::THRESHOLDS+2];
      t4 = thr[ch*wheel_speed_pkg::THRESHOLDS+3];
      next_st.under[ch] = ~t1;
      if (st.sensor_type == wheel_speed_pkg::TYPE_INTELLIGENT) begin
        next_st.over[ch] = t4;
        next_st.speed[ch] = t3;
        next_st.diag_seen[ch] = (t2 & ~t3) | (st.diag_seen[ch] & ~(t3 & ~st.speed[ch]));
        if (t3 && !st.speed[ch]) begin
          next_st.diag_shift[ch] = {st.diag_shift[ch][7:0], st.diag_seen[ch]};
          if (st.diag_cnt[ch] == wheel_speed_pkg::DIAG_LAST) begin
            next_st.diag_word[ch] = {st.diag_shift[ch][7:0], st.diag_seen[ch]};
            next_st.diag_cnt[ch] = 4'h0;
          end else begin
            next_st.diag_cnt[ch] = st.diag_cnt[ch] + 4'h1;
          end
        end
      end else begin
        next_st.over[ch] = t3;
        next_st.speed[ch] = t2;
        next_st.diag_seen[ch] = 1'b0;
      end
      // A new cause always wins over a clearing read.
      next_st.stb_flag[ch] = stb_cond[ch] | (st.stb_flag[ch] & ~rd_stb_hit[ch]);
      next_st.sup_oc_flag[ch] = sup_oc[ch] | (st.sup_oc_flag[ch] & ~rd_limit);
      next_st.ret_oc_flag[ch] = ret_cond[ch] | (st.ret_oc_flag[ch] & ~rd_sense);
      next_st.sense_fault_flag[ch] = sense_cond[ch]
                                     | (st.sense_fault_flag[ch] & ~rd_sense);
    end

    // Edge of the selected speed output, taken from the registered level and
    // its next value, so that a change of select alone never counts.
    sel_edge = next_st.speed[sel_idx] ^ st.speed[sel_idx];

    // Open-drain flags.
    next_st.od_lim_flag = od_oc | (st.od_lim_flag & {2{~rd_od}});
    next_st.od_gnd_flag = od_gnd_cond | (st.od_gnd_flag & {2{~rd_od}});

    // Edge counter with saturation and control conflict detection.
    if (count_clear_pin) begin
      next_st.count = 8'h00;
    end else if (cnt_en && sel_edge && st.count != wheel_speed_pkg::COUNT_MAX) begin
      next_st.count = st.count + 8'h01;
    end
    next_st.cnt_ovf_flag = (st.count == wheel_speed_pkg::COUNT_MAX)
                           | (st.cnt_ovf_flag & ~rd_od);
    next_st.cnt_conf_flag = (count_clear_pin & cnt_en) | (st.cnt_conf_flag & ~rd_od);

    // Register writes.
    if (reg_wr_i) begin
      case (reg_addr_i)
        wheel_speed_pkg::OFF_SUPPLY_EN: begin
          next_st.sup_en = reg_wdata_i[wheel_speed_pkg::SUP_EN_LSB +: 4];
        end
        wheel_speed_pkg::OFF_RETURN_EN: begin
          next_st.ret_en = reg_wdata_i[wheel_speed_pkg::RET_EN_LSB +: 4];
          next_st.od_en = reg_wdata_i[wheel_speed_pkg::OD_EN_LSB +: 2];
        end
        wheel_speed_pkg::OFF_TYPE_LIMIT: begin
          next_st.sensor_type = reg_wdata_i[wheel_speed_pkg::TYPE_BIT];
          next_st.cnt_sel[0] = reg_wdata_i[wheel_speed_pkg::SEL0_BIT];
          next_st.cnt_sel[1] = reg_wdata_i[wheel_speed_pkg::SEL1_BIT];
        end
        default: begin
        end
      endcase
    end

    // Supervisor events clear every enable bit.
    if (shutdown) begin
      next_st.sup_en = 4'h0;
      next_st.ret_en = 4'h0;
      next_st.od_en = 2'h0;
    end

    // Read data, captured before any clear takes effect.
    case (reg_addr_i)
      wheel_speed_pkg::OFF_COUNT: rd = st.count;
      wheel_speed_pkg::OFF_OD_COUNT_FLAGS: begin
        rd[wheel_speed_pkg::OD_LIM_LSB +: 2] = st.od_lim_flag;
        rd[wheel_speed_pkg::OD_GND_LSB +: 2] = st.od_gnd_flag;
        rd[wheel_speed_pkg::CNT_OVF_BIT] = st.cnt_ovf_flag;
        rd[wheel_speed_pkg::CNT_CONF_BIT] = st.cnt_conf_flag;
      end
      wheel_speed_pkg::OFF_STB1: rd[wheel_speed_pkg::STB_BIT] = st.stb_flag[0];
      wheel_speed_pkg::OFF_STB2: rd[wheel_speed_pkg::STB_BIT] = st.stb_flag[1];
      wheel_speed_pkg::OFF_STB3: rd[wheel_speed_pkg::STB_BIT] = st.stb_flag[2];
      wheel_speed_pkg::OFF_STB4: rd[wheel_speed_pkg::STB_BIT] = st.stb_flag[3];
      wheel_speed_pkg::OFF_SENSE_FAULTS: begin
        rd[wheel_speed_pkg::RET_OC_LSB +: 4] = st.ret_oc_flag;
        rd[wheel_speed_pkg::SENSE_FAULT_LSB +: 4] = st.sense_fault_flag;
      end
      wheel_speed_pkg::OFF_SUPPLY_EN: rd[wheel_speed_pkg::SUP_EN_LSB +: 4] = st.sup_en;
      wheel_speed_pkg::OFF_RETURN_EN: begin
        rd[wheel_speed_pkg::RET_EN_LSB +: 4] = st.ret_en;
        rd[wheel_speed_pkg::OD_EN_LSB +: 2] = st.od_en;
      end
      wheel_speed_pkg::OFF_TYPE_LIMIT: begin
        rd[wheel_speed_pkg::TYPE_BIT] = st.sensor_type;
        rd[wheel_speed_pkg::SEL0_BIT] = st.cnt_sel[0];
        rd[wheel_speed_pkg::SEL1_BIT] = st.cnt_sel[1];
        rd[wheel_speed_pkg::SUP_OC_LSB +: 4] = st.sup_oc_flag;
      end
      default: rd = 8'h00;
    endcase
    if (reg_rd_i) begin
      next_st.rdata = rd;
    end
  end

  // ---------------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------------
  // Registers the whole state. The reset pin chain starts low, so shutdown
  // holds the enables clear for a few cycles after reset is released.
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  // Checks run on the device clock and stop while reset is held.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  supply_enable_gate_a: assert property ((sensor_supply_switch_o & ~st.sup_en) == 4'h0)
    else $error("Supply switch on without enable.");
  return_enable_gate_a: assert property ((sensor_return_switch_o & ~st.ret_en) == 4'h0)
    else $error("Return switch on without enable.");
  supply_oc_trip_a: assert property (sup_oc[0] |=> st.sup_oc_flag[0]
    && !sensor_supply_switch_o[0] && st.sup_en[0] == $past(st.sup_en[0]) || $past(shutdown))
    else $error("Supply overcurrent did not trip channel 1.");
  flag_held_a: assert property (st.ret_oc_flag[1] && ret_cond[1] && rd_sense
    |=> st.ret_oc_flag[1])
    else $error("Flag cleared while cause present.");
  return_oc_trip_a: assert property (ret_oc[0] && !shutdown |=> st.ret_oc_flag[0]
    && !sensor_return_switch_o[0])
    else $error("Return overcurrent did not stop return switch.");
  shutdown_clear_a: assert property (shutdown |=> st.sup_en == 4'h0 && st.ret_en == 4'h0
    && st.od_en == 2'h0 && sensor_supply_switch_o == 4'h0)
    else $error("Shutdown left enables set.");
  speed_follow_a: assert property (##1 digital_speed_out_o[3] == ($past(st.sensor_type)
    ? $past(thr[13]) : $past(thr[14])))
    else $error("Speed output does not follow threshold.");
  count_clear_a: assert property (count_clear_pin |=> pulse_count_o == 8'h00)
    else $error("Counter not cleared.");
  count_saturate_a: assert property (st.count == wheel_speed_pkg::COUNT_MAX && !count_clear_pin
    |=> st.count == wheel_speed_pkg::COUNT_MAX && st.cnt_ovf_flag)
    else $error("Counter did not saturate with overflow.");

endmodule // wheel_speed_channel_control

// >>> bench/wheel_sensor_model.sv
// Purpose: Behavioural set of four wheel-speed sensors on the far side.
// Assumes: A sensor draws current only while both its switches conduct.
// Notes:   Level codes are 0 under, 1 low, 2 diag, 3 high and 4 over.
`timescale 1ns/1ps

module wheel_sensor_model (
  // Switch drives seen by the sensors.
  input wire logic [3:0] supply_i,
  input wire logic [3:0] return_i,
  // Fitted sensor type and per-channel current level.
  input wire logic active_i,
  input wire logic [11:0] level_i,
  // Comparator view of the sensor currents.
  output logic [15:0] above_o
);
  // Maps each current level onto the threshold ladder of the fitted type.
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      case (level_i[c*3 +: 3])
        3'h1: above_o[c*4 +: 4] = 4'h1;
        3'h2: above_o[c*4 +: 4] = 4'h3;
        3'h3: above_o[c*4 +: 4] = active_i ? 4'h3 : 4'h7;
        3'h4: above_o[c*4 +: 4] = active_i ? 4'h7 : 4'hf;
        default: above_o[c*4 +: 4] = 4'h0;
      endcase
      // A sensor without supply or ground path draws nothing.
      if (!(supply_i[c] && return_i[c])) begin
        above_o[c*4 +: 4] = 4'h0;
      end
    end
  end
endmodule // wheel_sensor_model

// >>> bench/test_wheel_speed_channel_control.sv
// Purpose: Self-checking bench for the wheel-speed channel control block.
// Assumes: Inputs change at the falling edge; synchronisers need two edges.
// Notes:   Sensor currents come from the behavioural sensor model.
`timescale 1ns/1ps

module test_wheel_speed_channel_control;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, cnt, exp;
  logic wr = 1'b0, rd = 1'b0, active = 1'b0;
  logic [3:0] sup_oc = 4'h0, stb = 4'h0, ret_oc = 4'h0, sns_bat = 4'h0;
  logic [3:0] sns_gnd = 4'h0, ret_gnd = 4'h0, sup_sw, ret_sw, spd, ucur, ocur;
  logic [1:0] od_oc = 2'h0, od_gnd = 2'h0, od, od_oe;
  logic uv = 1'b0, ov = 1'b0, ext_low = 1'b0, cclr = 1'b0, cen = 1'b0, rst_o, rst_oe;
  logic [15:0] above;
  logic [35:0] diag;
  logic [11:0] level = 12'h000;
  int bad_count = 0;
  int checked = 0;

  // Free-running 125 MHz clock.
  always #4 clk_i = ~clk_i;

  // Reset pin wire: pulled up, low while either party pulls it.
  wire logic rst_pin = ~(rst_oe | ext_low);

  wheel_speed_channel_control u_dut (
    .clk_i(clk_i), .reset_n_i(reset_n_i),
    .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .threshold_above_i(above), .supply_overcurrent_i(sup_oc),
    .supply_battery_short_status_i(stb), .return_overcurrent_i(ret_oc),
    .sense_battery_short_i(sns_bat), .sense_ground_short_i(sns_gnd),
    .return_ground_short_i(ret_gnd), .open_drain_overcurrent_i(od_oc),
    .open_drain_ground_short_i(od_gnd), .supply_undervoltage_i(uv),
    .battery_overvoltage_i(ov), .reset_out_pin_i(rst_pin), .count_clear_pin_i(cclr),
    .count_enable_pin_i(cen), .sensor_supply_switch_o(sup_sw), .sensor_return_switch_o(ret_sw),
    .open_drain_speed_out_o(od), .open_drain_speed_out_oe_o(od_oe), .reset_out_pin_o(rst_o),
    .reset_out_pin_oe_o(rst_oe), .digital_speed_out_o(spd), .sensor_undercurrent_o(ucur),
    .sensor_overcurrent_o(ocur), .diag_words_o(diag), .pulse_count_o(cnt)
  );

  wheel_sensor_model u_sensors (
    .supply_i(sup_sw), .return_i(ret_sw), .active_i(active), .level_i(level), .above_o(above)
  );

  // Mismatch reporting, comparisons and bus cycles.
  task automatic fail(input string msg);
    bad_count++;
    $display("[ERR] %0t %s", $time, msg);
  endtask
  task automatic chk_reg(input logic [7:0] got, input logic [7:0] want);
    checked++;
    if (got !== want) fail($sformatf("register read %h, expected %h", got, want));
  endtask
  task automatic chk_pin(input logic [3:0] got, input logic [3:0] want);
    checked++;
    if (got !== want) fail($sformatf("pins show %h, expected %h", got, want));
  endtask
  task automatic chk_diag(input logic [8:0] got, input logic [8:0] want);
    checked++;
    if (got !== want) fail($sformatf("diagnostic word %h, expected %h", got, want));
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk_i);
    wr = 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] want);
    @(negedge clk_i);
    addr = a;
    rd = 1'b1;
    @(negedge clk_i);
    rd = 1'b0;
    chk_reg(rdata, want);
  endtask
  // Swaps one sensor between its low and high speed levels.
  task automatic toggle(input int ch);
    level[ch*3 +: 3] = level[ch*3 +: 3] ^ 3'h2;
    settle(5);
  endtask
  task automatic give_verdict();
    $display("Counts: %0d comparisons, %0d mismatches", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run length.
  initial begin
    #400000;
    fail("watchdog expired");
    give_verdict();
  end

  // Main test sequence.
  initial begin
    repeat (20) @(negedge clk_i);
    reset_n_i = 1'b1;
    settle(6);
    rd_chk(8'h1b, 8'h00);
    rd_chk(8'h30, 8'h00);
    wr_reg(8'h1b, 8'h0f);
    wr_reg(8'h1c, 8'h3f);
    level = 12'h249;
    settle(5);
    rd_chk(8'h1c, 8'h3f);
    chk_pin(sup_sw, 4'hf);
    chk_pin(ret_sw, 4'hf);
    chk_pin(spd, 4'h0);
    wr_reg(8'h1b, 8'h05);
    settle(3);
    chk_pin(sup_sw, 4'h5);
    wr_reg(8'h1b, 8'h0f);
    $display("test enables done");
    // Classification for both sensor types.
    level = 12'h6db;
    settle(5);
    chk_pin(spd, 4'hf);
    chk_pin({od, od_oe}, 4'h3);
    od_oc = 2'h1;
    settle(5);
    chk_pin({2'b00, od_oe}, 4'h2);
    od_oc = 2'h0;
    settle(5);
    rd_chk(8'h05, 8'h01);
    level = 12'h492;
    settle(5);
    chk_pin(spd, 4'h0);
    level = 12'h924;
    settle(5);
    chk_pin(ocur, 4'hf);
    level = 12'h000;
    settle(5);
    chk_pin(ucur, 4'hf);
    active = 1'b1;
    wr_reg(8'h1d, 8'h01);
    level = 12'h6db;
    settle(5);
    chk_pin(spd, 4'hf);
    level = 12'h924;
    settle(5);
    chk_pin(ocur, 4'hf);
    active = 1'b0;
    wr_reg(8'h1d, 8'h00);
    level = 12'h249;
    $display("test classification done");
    // Supply overcurrent and supply short to battery.
    sup_oc = 4'h1;
    settle(5);
    chk_pin(sup_sw, 4'he);
    chk_pin(ret_sw, 4'hf);
    rd_chk(8'h1b, 8'h0f);
    rd_chk(8'h1d, 8'h10);
    rd_chk(8'h1d, 8'h10);
    sup_oc = 4'h0;
    settle(5);
    rd_chk(8'h1d, 8'h10);
    rd_chk(8'h1d, 8'h00);
    stb = 4'h8;
    settle(5);
    rd_chk(8'h0e, 8'h00);
    chk_pin(ret_sw, 4'hf);
    wr_reg(8'h1b, 8'h07);
    settle(5);
    rd_chk(8'h0e, 8'h01);
    stb = 4'h0;
    settle(5);
    rd_chk(8'h0e, 8'h01);
    rd_chk(8'h0e, 8'h00);
    wr_reg(8'h1b, 8'h0f);
    // Open-drain ground short while its output is off.
    od_gnd = 2'h1;
    settle(5);
    rd_chk(8'h05, 8'h04);
    chk_pin(sup_sw & ret_sw, 4'hf);
    od_gnd = 2'h0;
    settle(5);
    rd_chk(8'h05, 8'h04);
    rd_chk(8'h05, 8'h00);
    $display("test supply faults done");
    // Sense path faults, each followed by the return recovery sequence.
    for (int i = 0; i < 4; i++) begin
      case (i)
        0: ret_oc = 4'h1;
        1: sns_bat = 4'h2;
        2: sns_gnd = 4'h4;
        default: ret_gnd = 4'h8;
      endcase
      settle(5);
      exp = (i < 2) ? (8'h01 << i) : (8'h10 << i);
      rd_chk(8'h0f, exp);
      chk_pin(sup_sw, 4'hf);
      if (i != 1) chk_pin(ret_sw, (i == 0) ? 4'he : 4'hf);
      {ret_oc, sns_bat, sns_gnd, ret_gnd} = 16'h0000;
      settle(5);
      rd_chk(8'h0f, exp);
      rd_chk(8'h0f, 8'h00);
      wr_reg(8'h1b, 8'h00);
      wr_reg(8'h1c, 8'h3f);
      wr_reg(8'h1b, 8'h0f);
      settle(5);
      chk_pin(ret_sw, 4'hf);
    end
    $display("test sense faults done");
    // Undervoltage, overvoltage and external reset shut everything down.
    for (int e = 0; e < 3; e++) begin
      case (e)
        0: uv = 1'b1;
        1: ov = 1'b1;
        default: ext_low = 1'b1;
      endcase
      settle(5);
      chk_pin(sup_sw | ret_sw, 4'h0);
      chk_pin({rst_o, rst_oe, od_oe}, (e == 0) ? 4'h4 : 4'h0);
      {uv, ov, ext_low} = 3'b000;
      settle(6);
      rd_chk(8'h1b, 8'h00);
      rd_chk(8'h1c, 8'h00);
      wr_reg(8'h1c, 8'h3f);
      wr_reg(8'h1b, 8'h0f);
    end
    $display("test shutdown done");
    // Edge counter: every select code, clear, conflict and overflow.
    cen = 1'b1;
    for (int c = 0; c < 4; c++) begin
      wr_reg(8'h1d, {5'h00, c[0], c[1], 1'b0});
      cclr = 1'b1;
      settle(5);
      cclr = 1'b0;
      settle(5);
      rd_chk(8'h04, 8'h00);
      rd_chk(8'h05, 8'h20);
      repeat (c + 2) toggle(c);
      toggle((c + 1) % 4);
      toggle((c + 1) % 4);
      rd_chk(8'h04, 8'(c + 2));
      chk_reg(cnt, 8'(c + 2));
    end
    wr_reg(8'h1d, 8'h00);
    repeat (256) toggle(0);
    rd_chk(8'h04, 8'hff);
    rd_chk(8'h05, 8'h10);
    cen = 1'b0;
    cclr = 1'b1;
    settle(5);
    cclr = 1'b0;
    toggle(0);
    rd_chk(8'h05, 8'h10);
    rd_chk(8'h05, 8'h00);
    rd_chk(8'h04, 8'h00);
    $display("test counter done");
    // Diagnostic word on channel 1: seventeen set bits, then seventeen clear bits.
    for (int d = 0; d < 34; d++) begin
      level[2:0] = (d < 17) ? 3'h2 : 3'h1;
      settle(5);
      level[2:0] = 3'h3;
      settle(5);
      level[2:0] = 3'h1;
      settle(5);
      if (d == 16) chk_diag(diag[8:0], 9'h1ff);
    end
    chk_diag(diag[8:0], 9'h000);
    $display("test diagnostic done");
    give_verdict();
  end
endmodule // test_wheel_speed_channel_control
